// File: pulse_train_position_loop.v
/*
  Position loop logic of a motor drive: command pulse decoding, encoder
  feedback, position deviation, frequency command and speed error flag,
  with an AHB-Lite register slave. Assumes one clock, inputs synchronous
  to hclk, single-word transfers only.
*/
// Function
// - loop mode 0 speed, 1 incremental position, 2 absolute, 3 high-res absolute.
// - command format 0 quadrature, 1 direction plus pulse, 2 dual pulse trains.
// - command pulses enter the deviation only while command enable input is high.
// - clear input going on then off zeroes the position deviation.
// - speed error flag high while speed-command difference exceeds threshold.
// - position modes derive frequency command from command minus feedback.
// - encoder resolution held 128 to 65535, scales the feedback.
// - speed error threshold 0 to 120.0 Hz, coarse steps above 100 Hz.
// - position gain 0 to 100.0 rad/s, proportional deviation to speed.
// - pole count only 2, 4, 6, 8 or 10, used in speed conversion.
// - speed error flag routable to general outputs or alarm relay.
// - speed mode takes frequency from the external frequency register.
// - feedback active with sensor vector control or pulse train source.
// - pulse train frequency serves as process value when source is 3.
`timescale 1ns/1ps
`default_nettype none
`include "pulse_train_position_loop_consts.vh"

module pulse_train_position_loop #(
  parameter SPEED_WIN = `SPEED_WIN_MS * `CLK_KHZ
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire cmd_a,
  input wire cmd_b,
  input wire enc_a,
  input wire enc_b,
  input wire cmd_enable,
  input wire deviation_clear,
  output reg speed_error_flag,
  output reg [`GP_OUTS-1:0] gp_out,
  output reg alarm_relay,
  output reg [31:0] freq_cmd,
  output reg irq
);

  // ------------------------------------------------------------
  // pulse decode: returns {step, down}
  // ------------------------------------------------------------
  function [1:0] decode;
    input [1:0] fmt;
    input pa;
    input pb;
    input a;
    input b;
    begin
      case (fmt)
        `QUADRATURE_FORMAT: decode = {(pa ^ a) ^ (pb ^ b), ~(pa ^ b)};
        `DIRECTION_FORMAT: decode = {a & ~pa, b};
        `DUAL_PULSE_FORMAT: decode = {(a & ~pa) ^ (b & ~pb), b & ~pb};
        default: decode = 2'b00;
      endcase
    end
  endfunction

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  reg [15:0] ctrl_ff;
  reg [15:0] enc_res_ff;
  reg [15:0] gain_ff;
  reg [15:0] thr_ff;
  reg [7:0] poles_ff;
  reg [5:0] route_ff;
  reg [`ST_WIDTH-1:0] status_ff;
  reg [`ST_WIDTH-1:0] mask_ff;
  reg [31:0] ext_freq_ff;
  reg [31:0] target_ff;
  reg [31:0] pv_ff;
  reg wr_pend_ff;
  reg [7:0] wr_addr_ff;
  reg cmd_a_ff, cmd_b_ff, enc_a_ff, enc_b_ff, clr_ff;
  reg [31:0] dev_ff;
  reg [31:0] pos_ff;
  reg [31:0] enc_cnt_ff;
  reg [31:0] cmd_cnt_ff;
  reg [31:0] enc_win_ff;
  reg [31:0] speed_ff;
  reg [31:0] win_cnt_ff;
  reg err_ff;

  wire [1:0] loop_mode_select = ctrl_ff[`CTRL_LOOP_HI:`CTRL_LOOP_LO];
  wire [1:0] command_format_select = ctrl_ff[`CTRL_FMT_HI:`CTRL_FMT_LO];
  wire [3:0] control_method_select = ctrl_ff[`CTRL_METH_HI:`CTRL_METH_LO];
  wire [3:0] command_source_select = ctrl_ff[`CTRL_SRC_HI:`CTRL_SRC_LO];
  wire [3:0] process_value_source = ctrl_ff[`CTRL_PV_HI:`CTRL_PV_LO];

  // ------------------------------------------------------------
  // bus address phase
  // ------------------------------------------------------------
  wire addr_ok = hsel & hready & htrans[1];
  wire rd_take = addr_ok & ~hwrite;
  wire [7:0] a_off = haddr[7:0];
  wire status_rd = rd_take & (a_off == `OFS_STATUS);

  // ------------------------------------------------------------
  // pulse events
  // ------------------------------------------------------------
  wire feedback_active = (control_method_select == `SENSOR_VECTOR_CODE) |
                         (command_source_select == `PULSE_TRAIN_SOURCE);
  wire [1:0] cmd_dec = decode(command_format_select, cmd_a_ff, cmd_b_ff, cmd_a, cmd_b);
  wire [1:0] enc_dec = decode(`QUADRATURE_FORMAT, enc_a_ff, enc_b_ff, enc_a, enc_b);
  wire position_mode = (loop_mode_select != `SPEED_LOOP_MODE);
  wire cmd_step = cmd_dec[1] & cmd_enable & position_mode;
  wire fb_step = enc_dec[1] & feedback_active;
  wire clr_event = clr_ff & ~deviation_clear;
  wire win_end = (win_cnt_ff == SPEED_WIN - 1);

  // ------------------------------------------------------------
  // speed window: a step on the closing edge opens the next window
  // ------------------------------------------------------------
  wire [31:0] enc_base = win_end ? 32'h0000_0000 : enc_cnt_ff;
  wire [31:0] cmd_base = win_end ? 32'h0000_0000 : cmd_cnt_ff;

  // ------------------------------------------------------------
  // deviation accumulator
  // ------------------------------------------------------------
  reg signed [33:0] dev_sum;
  reg [31:0] nxt_dev;
  reg dev_sat;
  always @* begin
    dev_sum = {{2{dev_ff[31]}}, dev_ff};
    if (cmd_step) begin
      dev_sum = cmd_dec[0] ? dev_sum - 34'sd1 : dev_sum + 34'sd1;
    end
    if (fb_step) begin
      dev_sum = enc_dec[0] ? dev_sum + 34'sd1 : dev_sum - 34'sd1;
    end
    dev_sat = 1'b0;
    if (dev_sum > $signed({2'b00, `DEV_MAX})) begin
      nxt_dev = `DEV_MAX;
      dev_sat = 1'b1;
    end else if (dev_sum < $signed({2'b11, `DEV_MIN})) begin
      nxt_dev = `DEV_MIN;
      dev_sat = 1'b1;
    end else begin
      nxt_dev = dev_sum[31:0];
    end
    if (clr_event) begin
      nxt_dev = 32'h0000_0000;
      dev_sat = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // speed and frequency command arithmetic
  // ------------------------------------------------------------
  reg signed [63:0] calc_speed;
  reg signed [63:0] calc_freq;
  reg signed [31:0] dev_eff;
  reg [31:0] nxt_freq;
  reg signed [32:0] diff;
  reg [32:0] diff_abs;
  always @* begin
    calc_speed = ($signed({{32{enc_win_ff[31]}}, enc_win_ff}) *
                  $signed({56'h0, poles_ff}) * `SPEED_SCALE) /
                 $signed({48'h0, enc_res_ff});
    case (loop_mode_select)
      `ABS_POSITION_MODE: dev_eff = $signed(target_ff - pos_ff) >>> 2;
      `HIRES_ABS_MODE: dev_eff = $signed(target_ff - pos_ff);
      default: dev_eff = $signed(dev_ff);
    endcase
    calc_freq = ($signed({{32{dev_eff[31]}}, dev_eff}) * $signed({48'h0, gain_ff}) *
                 $signed({56'h0, poles_ff})) / $signed({45'h0, enc_res_ff, 3'b000});
    if (position_mode) begin
      nxt_freq = calc_freq[31:0];
    end else begin
      nxt_freq = ext_freq_ff;
    end
    diff = $signed({speed_ff[31], speed_ff}) - $signed({freq_cmd[31], freq_cmd});
    diff_abs = diff[32] ? -diff : diff;
  end
  wire speed_err = (diff_abs > {17'h0, thr_ff});

  // ------------------------------------------------------------
  // pulse datapath
  // ------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_a_ff <= 1'b0;
      cmd_b_ff <= 1'b0;
      enc_a_ff <= 1'b0;
      enc_b_ff <= 1'b0;
      clr_ff <= 1'b0;
      dev_ff <= 32'h0000_0000;
      pos_ff <= 32'h0000_0000;
      enc_cnt_ff <= 32'h0000_0000;
      cmd_cnt_ff <= 32'h0000_0000;
      enc_win_ff <= 32'h0000_0000;
      speed_ff <= 32'h0000_0000;
      pv_ff <= 32'h0000_0000;
      win_cnt_ff <= 32'h0000_0000;
      freq_cmd <= 32'h0000_0000;
      err_ff <= 1'b0;
    end else begin
      cmd_a_ff <= cmd_a;
      cmd_b_ff <= cmd_b;
      enc_a_ff <= enc_a;
      enc_b_ff <= enc_b;
      clr_ff <= deviation_clear;
      dev_ff <= nxt_dev;
      if (clr_event && loop_mode_select[1]) begin
        pos_ff <= target_ff;
      end else if (fb_step) begin
        pos_ff <= enc_dec[0] ? pos_ff - 32'h0000_0001 : pos_ff + 32'h0000_0001;
      end
      win_cnt_ff <= win_end ? 32'h0000_0000 : win_cnt_ff + 32'h0000_0001;
      if (win_end) begin
        enc_win_ff <= enc_cnt_ff;
        pv_ff <= (process_value_source == `PV_PULSE_TRAIN) ? cmd_cnt_ff : 32'h0000_0000;
      end
      if (fb_step) begin
        enc_cnt_ff <= enc_dec[0] ? enc_base - 32'h0000_0001 : enc_base + 32'h0000_0001;
      end else begin
        enc_cnt_ff <= enc_base;
      end
      if (cmd_dec[1]) begin
        cmd_cnt_ff <= cmd_base + 32'h0000_0001;
      end else begin
        cmd_cnt_ff <= cmd_base;
      end
      speed_ff <= calc_speed[31:0];
      freq_cmd <= nxt_freq;
      err_ff <= speed_err;
    end
  end

  // ------------------------------------------------------------
  // error routing and interrupt
  // ------------------------------------------------------------
  wire [`ST_WIDTH-1:0] ev_set = {dev_sat, clr_event, speed_err & ~err_ff};
  wire [`ST_WIDTH-1:0] nxt_status = (status_rd ? {`ST_WIDTH{1'b0}} : status_ff) | ev_set;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      speed_error_flag <= 1'b0;
      gp_out <= {`GP_OUTS{1'b0}};
      alarm_relay <= 1'b0;
      status_ff <= {`ST_WIDTH{1'b0}};
      irq <= 1'b0;
    end else begin
      speed_error_flag <= err_ff;
      gp_out <= {`GP_OUTS{err_ff}} & route_ff[`GP_OUTS-1:0];
      alarm_relay <= err_ff & route_ff[`GP_OUTS];
      status_ff <= nxt_status;
      irq <= |(nxt_status & mask_ff);
    end
  end

  // ------------------------------------------------------------
  // register file and bus slave
  // ------------------------------------------------------------
  reg [31:0] rd_mux;
  always @* begin
    case (a_off)
      `OFS_CTRL: rd_mux = {16'h0000, ctrl_ff};
      `OFS_ENC_RES: rd_mux = {16'h0000, enc_res_ff};
      `OFS_POS_GAIN: rd_mux = {16'h0000, gain_ff};
      `OFS_SPD_THR: rd_mux = {16'h0000, thr_ff};
      `OFS_POLES: rd_mux = {24'h00_0000, poles_ff};
      `OFS_ERR_ROUTE: rd_mux = {26'h000_0000, route_ff};
      `OFS_STATUS: rd_mux = {29'h0000_0000, status_ff};
      `OFS_MASK: rd_mux = {29'h0000_0000, mask_ff};
      `OFS_DEVIATION: rd_mux = dev_eff;
      `OFS_FREQ_CMD: rd_mux = freq_cmd;
      `OFS_SPEED: rd_mux = speed_ff;
      `OFS_EXT_FREQ: rd_mux = ext_freq_ff;
      `OFS_ABS_TARGET: rd_mux = target_ff;
      `OFS_PV_VALUE: rd_mux = pv_ff;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  wire [15:0] wd16 = hwdata[15:0];
  wire poles_ok = (hwdata[7:0] == 8'h02) | (hwdata[7:0] == 8'h04) | (hwdata[7:0] == 8'h06) |
                  (hwdata[7:0] == 8'h08) | (hwdata[7:0] == 8'h0A);
  wire [15:0] thr_clip = (wd16 > `THR_MAX) ? `THR_MAX : wd16;
  wire [15:0] thr_coarse = thr_clip - (thr_clip % `THR_STEP);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      ctrl_ff <= `RST_CTRL;
      enc_res_ff <= `RST_ENC_RES;
      gain_ff <= `RST_GAIN;
      thr_ff <= `RST_THR;
      poles_ff <= `RST_POLES;
      route_ff <= 6'h00;
      mask_ff <= {`ST_WIDTH{1'b0}};
      ext_freq_ff <= 32'h0000_0000;
      target_ff <= 32'h0000_0000;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_ff <= addr_ok & hwrite;
      if (addr_ok) begin
        wr_addr_ff <= a_off;
      end
      if (rd_take) begin
        hrdata <= rd_mux;
      end
      if (wr_pend_ff) begin
        case (wr_addr_ff)
          `OFS_CTRL: ctrl_ff <= wd16;
          `OFS_ENC_RES: enc_res_ff <= (wd16 < `ENC_RES_MIN) ? `ENC_RES_MIN : wd16;
          `OFS_POS_GAIN: gain_ff <= (wd16 > `GAIN_MAX) ? `GAIN_MAX : wd16;
          `OFS_SPD_THR: thr_ff <= (thr_clip > `THR_FINE_MAX) ? thr_coarse : thr_clip;
          `OFS_POLES: poles_ff <= poles_ok ? hwdata[7:0] : poles_ff;
          `OFS_ERR_ROUTE: route_ff <= hwdata[5:0];
          `OFS_MASK: mask_ff <= hwdata[`ST_WIDTH-1:0];
          `OFS_EXT_FREQ: ext_freq_ff <= hwdata;
          `OFS_ABS_TARGET: target_ff <= hwdata;
          default: ctrl_ff <= ctrl_ff;
        endcase
      end
    end
  end

endmodule // pulse_train_position_loop

`default_nettype wire

// File: pulse_train_position_loop_consts.vh
/*
  Constants of the pulse train position loop: register offsets, field
  positions, mode codes, setting limits, reset values and timing.
  Assumes inclusion by the loop module, its checker and the bench; definitions only.
*/
`ifndef PULSE_TRAIN_POSITION_LOOP_CONSTS_VH
`define PULSE_TRAIN_POSITION_LOOP_CONSTS_VH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define OFS_CTRL       8'h00
`define OFS_ENC_RES    8'h04
`define OFS_POS_GAIN   8'h08
`define OFS_SPD_THR    8'h0C
`define OFS_POLES      8'h10
`define OFS_ERR_ROUTE  8'h14
`define OFS_STATUS     8'h18
`define OFS_MASK       8'h1C
`define OFS_DEVIATION  8'h20
`define OFS_FREQ_CMD   8'h24
`define OFS_SPEED      8'h28
`define OFS_EXT_FREQ   8'h2C
`define OFS_ABS_TARGET 8'h30
`define OFS_PV_VALUE   8'h34

// ------------------------------------------------------------
// control register fields
// ------------------------------------------------------------
`define CTRL_LOOP_LO   0
`define CTRL_LOOP_HI   1
`define CTRL_FMT_LO    2
`define CTRL_FMT_HI    3
`define CTRL_METH_LO   4
`define CTRL_METH_HI   7
`define CTRL_SRC_LO    8
`define CTRL_SRC_HI    11
`define CTRL_PV_LO     12
`define CTRL_PV_HI     15

// ------------------------------------------------------------
// codes
// ------------------------------------------------------------
`define SPEED_LOOP_MODE      2'h0
`define INCR_POSITION_MODE   2'h1
`define ABS_POSITION_MODE    2'h2
`define HIRES_ABS_MODE       2'h3
`define QUADRATURE_FORMAT    2'h0
`define DIRECTION_FORMAT     2'h1
`define DUAL_PULSE_FORMAT    2'h2
`define SENSOR_VECTOR_CODE   4'h5
`define PULSE_TRAIN_SOURCE   4'h6
`define PV_PULSE_TRAIN       4'h3

// ------------------------------------------------------------
// status bits
// ------------------------------------------------------------
`define ST_SPEED_ERR   0
`define ST_DEV_CLEAR   1
`define ST_DEV_SAT     2
`define ST_WIDTH       3

// ------------------------------------------------------------
// setting limits and reset values
// ------------------------------------------------------------
`define ENC_RES_MIN    16'h0080
`define GAIN_MAX       16'h2710
`define THR_MAX        16'h2EE0
`define THR_FINE_MAX   16'h270F
`define THR_STEP       16'h000A
`define RST_CTRL       16'h0000
`define RST_ENC_RES    16'h0400
`define RST_GAIN       16'h03E8
`define RST_THR        16'h01F4
`define RST_POLES      8'h04
`define DEV_MAX        32'h7FFF_FFFF
`define DEV_MIN        32'h8000_0000

// ------------------------------------------------------------
// timing and scaling
// ------------------------------------------------------------
`define CLK_KHZ        40000
`define SPEED_WIN_MS   10
`define SPEED_SCALE    64'sh0000_0000_0000_04E2
`define GP_OUTS        5

`endif

// File: pulse_train_position_loop_properties.sv
/* port checker of the pulse train position loop.
   assumes one clock, hready tied to hreadyout, bound to the loop module. */
`timescale 1ns/1ps
`default_nettype none
`include "pulse_train_position_loop_consts.vh"
module pulse_train_position_loop_checker #(
  parameter SPEED_WIN = `SPEED_WIN_MS * `CLK_KHZ
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic cmd_a,
  input wire logic cmd_b,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic cmd_enable,
  input wire logic deviation_clear,
  input wire logic speed_error_flag,
  input wire logic [`GP_OUTS-1:0] gp_out,
  input wire logic alarm_relay,
  input wire logic [31:0] freq_cmd,
  input wire logic irq
);
  // ----
  // activity tracking
  // ----
  logic rd_req, wr_req, act, ever_wr_ff, nxt_ever_wr;
  logic [4:0] pins_ff;
  logic [2:0] quiet_ff, nxt_quiet, wr_age_ff, nxt_wr_age;
  assign rd_req = hsel && hready && htrans[1] && !hwrite;
  assign wr_req = hsel && hready && htrans[1] && hwrite;
  assign act = wr_req || (pins_ff[4:2] != {deviation_clear, enc_a, enc_b})
    || (cmd_enable && (pins_ff[1:0] != {cmd_a, cmd_b}));
  assign nxt_quiet = act ? 3'h0 : (quiet_ff == 3'h7) ? quiet_ff : quiet_ff + 3'h1;
  assign nxt_wr_age = wr_req ? 3'h0 : (wr_age_ff == 3'h7) ? wr_age_ff : wr_age_ff + 3'h1;
  assign nxt_ever_wr = ever_wr_ff || wr_req;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pins_ff <= 5'h00;
      quiet_ff <= 3'h0;
      wr_age_ff <= 3'h7;
      ever_wr_ff <= 1'b0;
    end else begin
      pins_ff <= {deviation_clear, enc_a, enc_b, cmd_a, cmd_b};
      quiet_ff <= nxt_quiet;
      wr_age_ff <= nxt_wr_age;
      ever_wr_ff <= nxt_ever_wr;
    end
  end
  // ----
  // properties
  // ----
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  no_wait_a: assert property (hreadyout) else $error("hreadyout low");
  okay_resp_a: assert property (!hresp) else $error("hresp not okay");
  rdata_hold_a: assert property ($changed(hrdata) |-> $past(rd_req))
    else $error("hrdata moved without read");
  gp_follow_a: assert property ((gp_out != 5'h00) |-> speed_error_flag)
    else $error("gp_out set without speed error");
  alarm_follow_a: assert property (alarm_relay |-> speed_error_flag)
    else $error("alarm set without speed error");
  route_cause_a: assert property ($changed({gp_out, alarm_relay}) |->
    $changed(speed_error_flag) || (wr_age_ff <= 3'h3)) else $error("route output moved alone");
  quiet_freq_a: assert property ((quiet_ff == 3'h7) |-> $stable(freq_cmd))
    else $error("freq_cmd moved without cause");
  irq_idle_a: assert property (!ever_wr_ff |-> !irq) else $error("irq before any mask");
  cover property ($rose(speed_error_flag));
  cover property ($rose(irq));
  cover property ($fell(deviation_clear));
  cover property (rd_req ##1 hreadyout);
endmodule // pulse_train_position_loop_checker

bind pulse_train_position_loop pulse_train_position_loop_checker #(.SPEED_WIN(SPEED_WIN)) i_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cmd_a(cmd_a),
  .cmd_b(cmd_b), .enc_a(enc_a), .enc_b(enc_b), .cmd_enable(cmd_enable),
  .deviation_clear(deviation_clear), .speed_error_flag(speed_error_flag), .gp_out(gp_out),
  .alarm_relay(alarm_relay), .freq_cmd(freq_cmd), .irq(irq));
`default_nettype wire

// File: pulse_partner.sv
/* command pulse source and motor encoder model.
   assumes the bench calls its tasks; lines change just after hclk rises. */
`timescale 1ns/1ps
`default_nettype none
module pulse_partner (
  input wire logic clk,
  output var logic cmd_a,
  output var logic cmd_b,
  output var logic enc_a,
  output var logic enc_b
);
  initial begin
    cmd_a = 1'b0;
    cmd_b = 1'b0;
    enc_a = 1'b0;
    enc_b = 1'b0;
  end
  // ----
  // quarter period step, forward has b leading a
  // ----
  function automatic logic [1:0] quad(input logic a, input logic b, input logic rev);
    quad = ((a == b) ^ rev) ? {a, !b} : {!a, b};
  endfunction
  task automatic send_cmd(input logic [1:0] fmt, input logic rev, input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      if (fmt == 2'h0) begin
        {cmd_a, cmd_b} <= quad(cmd_a, cmd_b, rev);
      end else begin
        if (fmt == 2'h1) cmd_b <= rev;
        @(posedge clk);
        if (fmt == 2'h2 && rev) cmd_b <= 1'b1;
        else cmd_a <= 1'b1;
        @(posedge clk);
        cmd_a <= 1'b0;
        if (fmt == 2'h2) cmd_b <= 1'b0;
      end
      repeat (gap) @(posedge clk);
    end
  endtask
  task automatic enc_move(input logic rev, input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      {enc_a, enc_b} <= quad(enc_a, enc_b, rev);
      repeat (gap) @(posedge clk);
    end
  endtask
  task automatic park;
    @(posedge clk);
    cmd_a <= 1'b0;
    cmd_b <= 1'b0;
  endtask
endmodule // pulse_partner
`default_nettype wire

// File: tb_pulse_train_position_loop.sv
/* self-checking bench of the pulse train position loop.
   assumes the loop, its checker and the pulse partner model. */
`timescale 1ns/1ps
`default_nettype none
`include "pulse_train_position_loop_consts.vh"
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin n_fail++; \
  $display("BAD %s exp %0h got %0h", nm, ex, got); end end
module tb_pulse_train_position_loop;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, cmd_enable = 1'b0;
  logic deviation_clear = 1'b0, hreadyout, hresp, cmd_a, cmd_b, enc_a, enc_b, irq;
  logic speed_error_flag, alarm_relay;
  logic [1:0] htrans = 2'b00;
  logic [4:0] gp_out;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, freq_cmd, rd;
  int n_fail = 0, num_checks = 0, i, k, m, p;
  integer seed = 32'h0000_948b;
  always #12.5 hclk = ~hclk;
  pulse_train_position_loop #(.SPEED_WIN(64)) i_dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .cmd_a(cmd_a), .cmd_b(cmd_b), .enc_a(enc_a), .enc_b(enc_b), .cmd_enable(cmd_enable),
    .deviation_clear(deviation_clear), .speed_error_flag(speed_error_flag), .gp_out(gp_out),
    .alarm_relay(alarm_relay), .freq_cmd(freq_cmd), .irq(irq));
  pulse_partner i_src (.clk(hclk), .cmd_a(cmd_a), .cmd_b(cmd_b), .enc_a(enc_a), .enc_b(enc_b));
  // ----
  // tasks and expectations
  // ----
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic chk_rd(input string nm, input logic [7:0] a, input logic [31:0] ex);
    bus(1'b0, a, 32'h0000_0000);
    `CHK(nm, ex, rd)
  endtask
  task automatic settle;
    repeat (4) @(posedge hclk);
  endtask
  task automatic clr;
    @(posedge hclk);
    deviation_clear <= 1'b1;
    settle();
    deviation_clear <= 1'b0;
    settle();
  endtask
  task automatic stop_test;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  function automatic logic [31:0] thr_exp(input int v);
    thr_exp = (v > 12000) ? 12000 : (v > 9999) ? v - v % 10 : v;
  endfunction
  function automatic logic [31:0] ctrl_w(input int md, input int fm, input int me, input int sr,
    input int pv);
    ctrl_w = 32'(md) | 32'(fm) << `CTRL_FMT_LO | 32'(me) << `CTRL_METH_LO
      | 32'(sr) << `CTRL_SRC_LO | 32'(pv) << `CTRL_PV_LO;
  endfunction
  // ----
  // main sequence
  // ----
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    chk_rd("enc_res", `OFS_ENC_RES, 32'(`RST_ENC_RES));
    chk_rd("gain", `OFS_POS_GAIN, 32'(`RST_GAIN));
    chk_rd("thr", `OFS_SPD_THR, 32'(`RST_THR));
    chk_rd("poles", `OFS_POLES, 32'(`RST_POLES));
    chk_rd("unmapped", 8'h3C, 32'h0000_0000);
    for (i = 0; i < 6; i++) begin
      k = (i == 0) ? 5 : (i == 1) ? 10005 : (i == 2) ? 12995 : $unsigned($random(seed)) % 13000;
      wr(`OFS_SPD_THR, k);
      chk_rd("thr_lim", `OFS_SPD_THR, thr_exp(k));
      wr(`OFS_POS_GAIN, k + 500);
      chk_rd("gain_lim", `OFS_POS_GAIN, (k > 9500) ? 10000 : k + 500);
      wr(`OFS_ENC_RES, k / 80);
      chk_rd("enc_lim", `OFS_ENC_RES, (k / 80 < 128) ? 128 : k / 80);
    end
    p = 4;
    for (k = 0; k < 12; k++) begin
      wr(`OFS_POLES, k);
      if (k inside {2, 4, 6, 8, 10}) p = k;
      chk_rd("poles_set", `OFS_POLES, p);
    end
    wr(`OFS_ENC_RES, 32'(`RST_ENC_RES));
    wr(`OFS_POS_GAIN, 32'(`GAIN_MAX));
    for (i = 0; i < 3; i++) begin
      i_src.park();
      wr(`OFS_CTRL, ctrl_w(1, i, 5, 0, 0));
      clr();
      k = 1 + $unsigned($random(seed)) % 8;
      m = $unsigned($random(seed)) % 4;
      cmd_enable <= 1'b1;
      i_src.send_cmd(i, 1'b0, k, i);
      i_src.send_cmd(i, 1'b1, m, 0);
      settle();
      cmd_enable <= 1'b0;
      i_src.send_cmd(i, 1'b0, 3, 0);
      settle();
      chk_rd("dev_cmd", `OFS_DEVIATION, k - m);
      i_src.enc_move(1'b0, 2, i);
      settle();
      chk_rd("dev_enc", `OFS_DEVIATION, k - m - 2);
      `CHK("freq_zero", (k - m == 2), (freq_cmd == 32'h0000_0000))
    end
    wr(`OFS_CTRL, ctrl_w(1, 0, 0, 0, 0));
    clr();
    i_src.enc_move(1'b1, 3, 0);
    settle();
    chk_rd("enc_off", `OFS_DEVIATION, 0);
    wr(`OFS_CTRL, ctrl_w(1, 0, 0, 6, 0));
    i_src.enc_move(1'b1, 3, 0);
    settle();
    chk_rd("enc_src", `OFS_DEVIATION, 3);
    bus(1'b0, `OFS_STATUS, 32'h0000_0000);
    wr(`OFS_MASK, 32'h0000_0002);
    `CHK("irq_idle", 1'b0, irq)
    clr();
    chk_rd("dev_clr", `OFS_DEVIATION, 0);
    `CHK("irq_set", 1'b1, irq)
    bus(1'b0, `OFS_STATUS, 32'h0000_0000);
    `CHK("st_clr", 1'b1, rd[`ST_DEV_CLEAR])
    settle();
    `CHK("irq_drop", 1'b0, irq)
    wr(`OFS_MASK, 32'h0000_0000);
    clr();
    `CHK("irq_mask", 1'b0, irq)
    for (m = 2; m < 4; m++) begin
      wr(`OFS_CTRL, ctrl_w(m, 0, 5, 0, 0));
      wr(`OFS_ABS_TARGET, 100);
      clr();
      wr(`OFS_ABS_TARGET, 100 + m * 7);
      settle();
      chk_rd("abs_dev", `OFS_DEVIATION, (m == 2) ? m * 7 / 4 : m * 7);
    end
    wr(`OFS_CTRL, ctrl_w(0, 1, 5, 0, 0));
    clr();
    k = 1000 + $unsigned($random(seed)) % 5000;
    m = 1 + $unsigned($random(seed)) % 63;
    wr(`OFS_EXT_FREQ, k);
    wr(`OFS_SPD_THR, 500);
    wr(`OFS_ERR_ROUTE, m);
    cmd_enable <= 1'b1;
    i_src.send_cmd(2'h1, 1'b0, 4, 0);
    repeat (200) @(posedge hclk);
    chk_rd("spd_dev", `OFS_DEVIATION, 0);
    #1;
    `CHK("ext_freq", 32'(k), freq_cmd)
    `CHK("flag_on", 1'b1, speed_error_flag)
    `CHK("gp_route", m[4:0], gp_out)
    `CHK("alarm", m[5], alarm_relay)
    wr(`OFS_SPD_THR, 12000);
    repeat (200) @(posedge hclk);
    #1;
    `CHK("flag_off", 1'b0, speed_error_flag)
    `CHK("gp_off", 5'h00, gp_out)
    wr(`OFS_CTRL, ctrl_w(1, 1, 5, 0, 3));
    fork
      i_src.send_cmd(2'h1, 1'b0, 100, 0);
      begin
        repeat (200) @(posedge hclk);
        bus(1'b0, `OFS_PV_VALUE, 32'h0000_0000);
      end
    join
    `CHK("pv_rate", 1'b1, rd inside {21, 22})
    wr(`OFS_CTRL, ctrl_w(1, 1, 5, 0, 0));
    repeat (70) @(posedge hclk);
    chk_rd("pv_off", `OFS_PV_VALUE, 0);
    stop_test();
  end
  initial begin
    repeat (30000) @(posedge hclk);
    n_fail++;
    $display("BAD watchdog exp done got timeout");
    stop_test();
  end
endmodule // tb_pulse_train_position_loop
`default_nettype wire
